// ==== rtl/cmp_ctrl_defines.vh ====
// Constants for the voltage comparator control block
`ifndef CMP_CTRL_DEFINES_VH
`define CMP_CTRL_DEFINES_VH

// Register addresses
`define CMP_ADDR_CONTROL      8'h9b
`define CMP_ADDR_MODE_SELECT  8'h9d
`define CMP_ADDR_INPUT_SELECT 8'h9f

// Reset values
`define CMP_CONTROL_RST       8'h00
`define CMP_MODE_RST          8'h02
`define CMP_INPUT_SEL_RST     8'hff
`define CMP_RDATA_IDLE        8'h00

// Control register fields
`define CMP_CTL_ENABLE_BIT    7
`define CMP_CTL_RESULT_BIT    6
`define CMP_CTL_RISE_BIT      5
`define CMP_CTL_FALL_BIT      4
`define CMP_CTL_PHYST_HI      3
`define CMP_CTL_PHYST_LO      2
`define CMP_CTL_NHYST_HI      1
`define CMP_CTL_NHYST_LO      0
`define CMP_CTL_ENABLE_RST    1'b0

// Mode register fields
`define CMP_MD_RISE_IE_BIT    5
`define CMP_MD_FALL_IE_BIT    4
`define CMP_MD_RESP_HI        1
`define CMP_MD_RESP_LO        0
`define CMP_MD_RESP_RST       2'h2

// Input select fields
`define CMP_MX_NEG_HI         7
`define CMP_MX_NEG_LO         4
`define CMP_MX_POS_HI         3
`define CMP_MX_POS_LO         0
`define CMP_MX_RST            4'hf

// Input select codes
`define CMP_SEL_REGULATOR     4'h8
`define CMP_SEL_PIN_LIMIT     4'h8
`define CMP_SEL_PIN_CNT       8

// Hysteresis codes
`define CMP_HYST_OFF          2'h0
`define CMP_HYST_5MV          2'h1
`define CMP_HYST_10MV         2'h2
`define CMP_HYST_20MV         2'h3

`endif

// ==== rtl/level_sync.v ====
// Two-flip-flop synchroniser for one asynchronous level
`timescale 1ns/100ps
module level_sync (
    // Clock and reset
    input  wire mclk,
    input  wire rst_n,
    // Level
    input  wire async_in,
    output reg  sync_out
);

    reg meta_r;

    always @(posedge mclk) begin
        if (!rst_n) begin
            meta_r   <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule

// ==== rtl/cmp_ctrl.v ====
// Control and status registers of the on-chip voltage comparator
//
// Contract
// - Control bit 6 reads the comparator result, high when positive input is higher.
// - Rising edge of the result sets control bit 5 until software writes zero.
// - Falling edge of the result sets control bit 4 until software writes zero.
// - Control bits 3:2 drive the positive hysteresis code: off, 5, 10, 20 mV.
// - Control bits 1:0 drive the negative hysteresis code with the same encoding.
// - Mode bit 5 is the read/write enable of the rising-edge interrupt.
// - Mode bit 4 is the read/write enable of the falling-edge interrupt.
// - Mode bits 7:6 and 3:2 read as zero and ignore writes.
// - Mode bits 1:0 drive response time: 00 fastest, 11 slowest and lowest power.
// - Select bits 7:4 choose negative input: odd pins, regulator, or nothing.
// - Select bits 3:0 choose positive input: even pins, regulator, or nothing.
// - Control bit 7 set enables the comparator; cleared disables it.
// - When disabled the routed output stays low and comparator power is off.
`timescale 1ns/100ps
`include "cmp_ctrl_defines.vh"
module cmp_ctrl (
    // Clock and reset
    input  wire       mclk,
    input  wire       rst_n,
    // Register port
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    // Analog comparator
    input  wire       cmp_raw_output,
    output reg        cmp_power_en,
    output reg  [1:0] cmp_pos_hyst,
    output reg  [1:0] cmp_neg_hyst,
    output reg  [1:0] cmp_response_mode,
    // Input multiplexer selects
    output reg  [7:0] cmp_pos_pin_sel,
    output reg        cmp_pos_regulator_sel,
    output reg  [7:0] cmp_neg_pin_sel,
    output reg        cmp_neg_regulator_sel,
    // Routed output and interrupt
    output reg        cmp_sync_output,
    output reg        cmp_irq
);

    // Register state
    reg        cmp_enable_r;
    reg        cmp_result_r;
    reg        cmp_rise_flag_r;
    reg        cmp_fall_flag_r;
    reg        cmp_rise_irq_en_r;
    reg        cmp_fall_irq_en_r;
    reg  [3:0] cmp_neg_input_sel_r;
    reg  [3:0] cmp_pos_input_sel_r;

    // Next values
    reg        cmp_enable_nxt;
    reg        cmp_result_nxt;
    reg        cmp_rise_flag_nxt;
    reg        cmp_fall_flag_nxt;
    reg  [1:0] cmp_pos_hyst_nxt;
    reg  [1:0] cmp_neg_hyst_nxt;
    reg        cmp_rise_irq_en_nxt;
    reg        cmp_fall_irq_en_nxt;
    reg  [1:0] cmp_response_mode_nxt;
    reg  [3:0] cmp_neg_input_sel_nxt;
    reg  [3:0] cmp_pos_input_sel_nxt;
    reg  [7:0] reg_rdata_nxt;

    // Decode
    reg        wr_control;
    reg        wr_mode;
    reg        wr_input_sel;
    reg        rd_control;
    reg        rd_mode;
    reg        rd_input_sel;

    // Comparator result path
    wire       cmp_sync_q;
    wire       rise_evt;
    wire       fall_evt;

    // Register images
    wire [7:0] control_image;
    wire [7:0] mode_image;
    wire [7:0] input_sel_image;

    // Decoded multiplexer selects
    reg  [7:0] pos_pin_dec;
    reg        pos_reg_dec;
    reg  [7:0] neg_pin_dec;
    reg        neg_reg_dec;
    integer    i;

    // Select code classes
    wire       pos_code_is_pin;
    wire       neg_code_is_pin;

    // Analog-side and interrupt next values
    reg        cmp_power_en_nxt;
    reg        cmp_sync_output_nxt;
    reg        cmp_irq_nxt;

    // Raw output crosses into the clock domain first
    level_sync u_result_sync (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .async_in (cmp_raw_output),
        .sync_out (cmp_sync_q)
    );

    // Address decode; unmapped addresses select nothing
    always @* begin
        wr_control   = 1'b0;
        wr_mode      = 1'b0;
        wr_input_sel = 1'b0;
        rd_control   = 1'b0;
        rd_mode      = 1'b0;
        rd_input_sel = 1'b0;
        if (reg_addr == `CMP_ADDR_CONTROL) begin
            wr_control = reg_wr;
            rd_control = reg_rd;
        end else if (reg_addr == `CMP_ADDR_MODE_SELECT) begin
            wr_mode = reg_wr;
            rd_mode = reg_rd;
        end else if (reg_addr == `CMP_ADDR_INPUT_SELECT) begin
            wr_input_sel = reg_wr;
            rd_input_sel = reg_rd;
        end
    end

    // Edges only counted while the comparator stays powered
    assign rise_evt = cmp_enable_r && cmp_sync_q && !cmp_result_r;
    assign fall_evt = cmp_enable_r && !cmp_sync_q && cmp_result_r;

    // Control register as read
    assign control_image = {cmp_enable_r,
                            cmp_result_r,
                            cmp_rise_flag_r,
                            cmp_fall_flag_r,
                            cmp_pos_hyst,
                            cmp_neg_hyst};

    // Unused mode bits read as zero
    assign mode_image = {2'h0,
                         cmp_rise_irq_en_r,
                         cmp_fall_irq_en_r,
                         2'h0,
                         cmp_response_mode};

    assign input_sel_image = {cmp_neg_input_sel_r, cmp_pos_input_sel_r};

    // Enable bit next state
    always @* begin
        cmp_enable_nxt = cmp_enable_r;
        if (wr_control) begin
            cmp_enable_nxt = reg_wdata[`CMP_CTL_ENABLE_BIT];
        end
    end

    // Hysteresis codes next state
    always @* begin
        cmp_pos_hyst_nxt = cmp_pos_hyst;
        cmp_neg_hyst_nxt = cmp_neg_hyst;
        if (wr_control) begin
            cmp_pos_hyst_nxt = reg_wdata[`CMP_CTL_PHYST_HI:`CMP_CTL_PHYST_LO];
            cmp_neg_hyst_nxt = reg_wdata[`CMP_CTL_NHYST_HI:`CMP_CTL_NHYST_LO];
        end
    end

    // Result follows the synchronised output, low while disabled
    always @* begin
        cmp_result_nxt = cmp_enable_r && cmp_sync_q;
    end

    // Sticky rising flag; a hardware edge beats a same-cycle software write
    always @* begin
        cmp_rise_flag_nxt = cmp_rise_flag_r;
        if (wr_control) begin
            cmp_rise_flag_nxt = reg_wdata[`CMP_CTL_RISE_BIT];
        end
        if (rise_evt) begin
            cmp_rise_flag_nxt = 1'b1;
        end
    end

    // Sticky falling flag, same priority
    always @* begin
        cmp_fall_flag_nxt = cmp_fall_flag_r;
        if (wr_control) begin
            cmp_fall_flag_nxt = reg_wdata[`CMP_CTL_FALL_BIT];
        end
        if (fall_evt) begin
            cmp_fall_flag_nxt = 1'b1;
        end
    end

    // Interrupt enables next state; unused mode bits are not stored
    always @* begin
        cmp_rise_irq_en_nxt = cmp_rise_irq_en_r;
        cmp_fall_irq_en_nxt = cmp_fall_irq_en_r;
        if (wr_mode) begin
            cmp_rise_irq_en_nxt = reg_wdata[`CMP_MD_RISE_IE_BIT];
            cmp_fall_irq_en_nxt = reg_wdata[`CMP_MD_FALL_IE_BIT];
        end
    end

    // Response mode next state
    always @* begin
        cmp_response_mode_nxt = cmp_response_mode;
        if (wr_mode) begin
            cmp_response_mode_nxt = reg_wdata[`CMP_MD_RESP_HI:`CMP_MD_RESP_LO];
        end
    end

    // Input select next state
    always @* begin
        cmp_neg_input_sel_nxt = cmp_neg_input_sel_r;
        cmp_pos_input_sel_nxt = cmp_pos_input_sel_r;
        if (wr_input_sel) begin
            cmp_neg_input_sel_nxt = reg_wdata[`CMP_MX_NEG_HI:`CMP_MX_NEG_LO];
            cmp_pos_input_sel_nxt = reg_wdata[`CMP_MX_POS_HI:`CMP_MX_POS_LO];
        end
    end

    // Codes below the pin limit pick a port pin
    assign pos_code_is_pin = (cmp_pos_input_sel_nxt < `CMP_SEL_PIN_LIMIT);
    assign neg_code_is_pin = (cmp_neg_input_sel_nxt < `CMP_SEL_PIN_LIMIT);

    // Multiplexer decode from the next select values, so outputs track the register
    always @* begin
        pos_pin_dec = 8'h00;
        neg_pin_dec = 8'h00;
        for (i = 0; i < `CMP_SEL_PIN_CNT; i = i + 1) begin
            if (pos_code_is_pin && (cmp_pos_input_sel_nxt == i[3:0])) begin
                pos_pin_dec[i] = 1'b1;
            end
            if (neg_code_is_pin && (cmp_neg_input_sel_nxt == i[3:0])) begin
                neg_pin_dec[i] = 1'b1;
            end
        end
        // Codes above the regulator code connect nothing
        pos_reg_dec = (cmp_pos_input_sel_nxt == `CMP_SEL_REGULATOR);
        neg_reg_dec = (cmp_neg_input_sel_nxt == `CMP_SEL_REGULATOR);
    end

    // Read data for the cycle after the strobe only; idle and unmapped read zero
    always @* begin
        if (rd_control) begin
            reg_rdata_nxt = control_image;
        end else if (rd_mode) begin
            reg_rdata_nxt = mode_image;
        end else if (rd_input_sel) begin
            reg_rdata_nxt = input_sel_image;
        end else begin
            reg_rdata_nxt = `CMP_RDATA_IDLE;
        end
    end

    // Control register
    always @(posedge mclk) begin
        if (!rst_n) begin
            cmp_enable_r          <= `CMP_CTL_ENABLE_RST;
            cmp_rise_flag_r       <= 1'b0;
            cmp_fall_flag_r       <= 1'b0;
            cmp_pos_hyst          <= `CMP_HYST_OFF;
            cmp_neg_hyst          <= `CMP_HYST_OFF;
        end else begin
            cmp_enable_r          <= cmp_enable_nxt;
            cmp_rise_flag_r       <= cmp_rise_flag_nxt;
            cmp_fall_flag_r       <= cmp_fall_flag_nxt;
            cmp_pos_hyst          <= cmp_pos_hyst_nxt;
            cmp_neg_hyst          <= cmp_neg_hyst_nxt;
        end
    end

    // Mode register
    always @(posedge mclk) begin
        if (!rst_n) begin
            cmp_rise_irq_en_r     <= 1'b0;
            cmp_fall_irq_en_r     <= 1'b0;
            cmp_response_mode     <= `CMP_MD_RESP_RST;
        end else begin
            cmp_rise_irq_en_r     <= cmp_rise_irq_en_nxt;
            cmp_fall_irq_en_r     <= cmp_fall_irq_en_nxt;
            cmp_response_mode     <= cmp_response_mode_nxt;
        end
    end

    // Input select register
    always @(posedge mclk) begin
        if (!rst_n) begin
            cmp_neg_input_sel_r   <= `CMP_MX_RST;
            cmp_pos_input_sel_r   <= `CMP_MX_RST;
        end else begin
            cmp_neg_input_sel_r   <= cmp_neg_input_sel_nxt;
            cmp_pos_input_sel_r   <= cmp_pos_input_sel_nxt;
        end
    end

    // Result state and read data
    always @(posedge mclk) begin
        if (!rst_n) begin
            cmp_result_r          <= 1'b0;
            reg_rdata             <= `CMP_RDATA_IDLE;
        end else begin
            cmp_result_r          <= cmp_result_nxt;
            reg_rdata             <= reg_rdata_nxt;
        end
    end

    // Routed output and interrupt use next values so they move with the flags
    always @* begin
        cmp_power_en_nxt    = cmp_enable_nxt;
        cmp_sync_output_nxt = cmp_enable_nxt && cmp_result_nxt;
        cmp_irq_nxt         = (cmp_rise_flag_nxt && cmp_rise_irq_en_nxt) ||
                              (cmp_fall_flag_nxt && cmp_fall_irq_en_nxt);
    end

    // Analog-side and interrupt outputs
    always @(posedge mclk) begin
        if (!rst_n) begin
            cmp_power_en          <= 1'b0;
            cmp_sync_output       <= 1'b0;
            cmp_irq               <= 1'b0;
        end else begin
            cmp_power_en          <= cmp_power_en_nxt;
            cmp_sync_output       <= cmp_sync_output_nxt;
            cmp_irq               <= cmp_irq_nxt;
        end
    end

    // Multiplexer select outputs
    always @(posedge mclk) begin
        if (!rst_n) begin
            cmp_pos_pin_sel       <= 8'h00;
            cmp_pos_regulator_sel <= 1'b0;
            cmp_neg_pin_sel       <= 8'h00;
            cmp_neg_regulator_sel <= 1'b0;
        end else begin
            cmp_pos_pin_sel       <= pos_pin_dec;
            cmp_pos_regulator_sel <= pos_reg_dec;
            cmp_neg_pin_sel       <= neg_pin_dec;
            cmp_neg_regulator_sel <= neg_reg_dec;
        end
    end

endmodule

// ==== dv/cmp_ctrl_chk.sv ====
// Port assertions for the comparator control register block
`timescale 1ns/100ps
module cmp_ctrl_chk (
    // Clock and reset
    input wire       mclk,
    input wire       rst_n,
    // Register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    // Comparator side
    input wire       cmp_raw_output,
    input wire       cmp_power_en,
    input wire [1:0] cmp_pos_hyst,
    input wire [1:0] cmp_neg_hyst,
    input wire [1:0] cmp_response_mode,
    input wire [7:0] cmp_pos_pin_sel,
    input wire       cmp_pos_regulator_sel,
    input wire [7:0] cmp_neg_pin_sel,
    input wire       cmp_neg_regulator_sel,
    input wire       cmp_sync_output,
    input wire       cmp_irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_mode_read;
        reg_rd && reg_addr == 8'h9d |=> reg_rdata[7:6] == 2'b00 && reg_rdata[3:2] == 2'b00;
    endproperty
    a_mode_read: assert property (p_mode_read) else $error("mode unused bits read nonzero");
    property p_resp;
        reg_wr && reg_addr == 8'h9d |=> cmp_response_mode == $past(reg_wdata[1:0]);
    endproperty
    a_resp: assert property (p_resp) else $error("response mode not taken from write");
    property p_physt;
        reg_wr && reg_addr == 8'h9b |=> cmp_pos_hyst == $past(reg_wdata[3:2]);
    endproperty
    a_physt: assert property (p_physt) else $error("positive hysteresis wrong");
    property p_nhyst;
        reg_wr && reg_addr == 8'h9b |=> cmp_neg_hyst == $past(reg_wdata[1:0]);
    endproperty
    a_nhyst: assert property (p_nhyst) else $error("negative hysteresis wrong");
    property p_power;
        reg_wr && reg_addr == 8'h9b |=> cmp_power_en == $past(reg_wdata[7]);
    endproperty
    a_power: assert property (p_power) else $error("power enable not taken from write");
    property p_sync_low;
        !cmp_power_en |-> !cmp_sync_output;
    endproperty
    a_sync_low: assert property (p_sync_low) else $error("output high while disabled");
    property p_pos_reg;
        reg_wr && reg_addr == 8'h9f && reg_wdata[3:0] == 4'h8 |=> cmp_pos_regulator_sel && cmp_pos_pin_sel == 8'h00;
    endproperty
    a_pos_reg: assert property (p_pos_reg) else $error("positive regulator select wrong");
    property p_neg_pin;
        reg_wr && reg_addr == 8'h9f && !reg_wdata[7]
            |=> cmp_neg_pin_sel == (8'h01 << $past(reg_wdata[6:4])) && !cmp_neg_regulator_sel;
    endproperty
    a_neg_pin: assert property (p_neg_pin) else $error("negative pin select wrong");
    property p_sync_follow;
        (cmp_power_en && cmp_raw_output) [*5] |-> cmp_sync_output;
    endproperty
    a_sync_follow: assert property (p_sync_follow) else $error("output did not follow raw");
    property p_irq_off;
        reg_wr && reg_addr == 8'h9d && reg_wdata[5:4] == 2'b00 |=> !cmp_irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt with both enables off");
    c_irq: cover property ($rose(cmp_irq));
    c_sync: cover property ($rose(cmp_sync_output));
    c_reg: cover property (cmp_neg_regulator_sel);
endmodule

bind cmp_ctrl cmp_ctrl_chk u_chk (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_raw_output(cmp_raw_output),
    .cmp_power_en(cmp_power_en), .cmp_pos_hyst(cmp_pos_hyst), .cmp_neg_hyst(cmp_neg_hyst),
    .cmp_response_mode(cmp_response_mode), .cmp_pos_pin_sel(cmp_pos_pin_sel),
    .cmp_pos_regulator_sel(cmp_pos_regulator_sel), .cmp_neg_pin_sel(cmp_neg_pin_sel),
    .cmp_neg_regulator_sel(cmp_neg_regulator_sel), .cmp_sync_output(cmp_sync_output), .cmp_irq(cmp_irq));

// ==== dv/testbench.sv ====
// Self-checking bench for the comparator control register block
`timescale 1ns/100ps
module testbench;
    reg        mclk = 1'b0;
    reg        rst_n = 1'b0;
    reg  [7:0] addr = 8'h00;
    reg  [7:0] wdata = 8'h00;
    reg        wr = 1'b0;
    reg        rd = 1'b0;
    reg        raw = 1'b0;
    wire [7:0] rdata, ppin, npin;
    wire [1:0] phy, nhy, rmode;
    wire       pwr, preg, nreg, sout, irq;
    integer    miscompares = 0;
    integer    compares = 0;
    integer    i;
    always #5 mclk = ~mclk;
    cmp_ctrl dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
        .reg_rdata(rdata), .cmp_raw_output(raw), .cmp_power_en(pwr), .cmp_pos_hyst(phy), .cmp_neg_hyst(nhy),
        .cmp_response_mode(rmode), .cmp_pos_pin_sel(ppin), .cmp_pos_regulator_sel(preg),
        .cmp_neg_pin_sel(npin), .cmp_neg_regulator_sel(nreg), .cmp_sync_output(sout), .cmp_irq(irq));
    function [7:0] pins(input [3:0] c);
        pins = (c < 4'h8) ? (8'h01 << c[2:0]) : 8'h00;
    endfunction
    task chk(input [7:0] seen, input [7:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("Error at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wreg(input [7:0] a, input [7:0] d);
        begin
            @(posedge mclk);
            wr <= 1'b1;
            addr <= a;
            wdata <= d;
            @(posedge mclk);
            wr <= 1'b0;
            #1;
        end
    endtask
    task rreg(input [7:0] a, input [7:0] exp);
        begin
            @(posedge mclk);
            rd <= 1'b1;
            addr <= a;
            @(posedge mclk);
            rd <= 1'b0;
            #1;
            chk(rdata, exp);
        end
    endtask
    // Raw level change, then time for two sync flops and the flag stage
    task drive_raw(input v);
        begin
            @(posedge mclk);
            raw <= v;
            repeat (5) @(posedge mclk);
            #1;
        end
    endtask
    task results;
        begin
            $display("compares %0d miscompares %0d", compares, miscompares);
            if (miscompares == 0 && compares > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    initial begin
        repeat (5000) @(posedge mclk);
        miscompares = miscompares + 1;
        results;
    end
    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        rreg(8'h9b, 8'h00);
        rreg(8'h9d, 8'h02);
        rreg(8'h9f, 8'hff);
        rreg(8'h9c, 8'h00);
        chk({6'h00, rmode}, 8'h02);
        wreg(8'h9d, 8'hff);
        rreg(8'h9d, 8'h33);
        for (i = 0; i < 4; i = i + 1) begin
            wreg(8'h9d, i[7:0]);
            chk({6'h00, rmode}, i[7:0]);
            wreg(8'h9b, {4'h4, i[1:0], ~i[1:0]});
            chk({4'h0, phy, nhy}, {4'h0, i[1:0], ~i[1:0]});
            rreg(8'h9b, {4'h0, i[1:0], ~i[1:0]});
        end
        for (i = 0; i < 16; i = i + 1) begin
            wreg(8'h9f, {i[3:0], ~i[3:0]});
            chk(npin, pins(i[3:0]));
            chk({7'h00, nreg}, {7'h00, i == 8});
            chk(ppin, pins(~i[3:0]));
            chk({7'h00, preg}, {7'h00, i == 7});
            rreg(8'h9f, {i[3:0], ~i[3:0]});
        end
        wreg(8'h9d, 8'h30);
        wreg(8'h9b, 8'h80);
        chk({7'h00, pwr}, 8'h01);
        drive_raw(1'b1);
        chk({6'h00, sout, irq}, 8'h03);
        rreg(8'h9b, 8'he0);
        wreg(8'h9b, 8'h80);
        chk({7'h00, irq}, 8'h00);
        rreg(8'h9b, 8'hc0);
        drive_raw(1'b0);
        chk({6'h00, sout, irq}, 8'h01);
        rreg(8'h9b, 8'h90);
        wreg(8'h9d, 8'h20);
        chk({7'h00, irq}, 8'h00);
        rreg(8'h9b, 8'h90);
        wreg(8'h9b, 8'h80);
        wreg(8'h9d, 8'h10);
        drive_raw(1'b1);
        chk({7'h00, irq}, 8'h00);
        rreg(8'h9b, 8'he0);
        wreg(8'h9b, 8'h00);
        chk({6'h00, pwr, sout}, 8'h00);
        drive_raw(1'b0);
        rreg(8'h9b, 8'h00);
        results;
    end
endmodule
